// ==== logic/msc_config_bank.sv ====
// configuration registers and power-up control of the monitor
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module msc_config_bank
   import msc_pkg::*;
#(
   parameter int FAN_WAIT = FAN_WAIT_CYC
) (
   input  wire logic                  i_clock,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_hsel,
   input  wire logic [31:0]           i_haddr,
   input  wire logic [1:0]            i_htrans,
   input  wire logic                  i_hwrite,
   input  wire logic [2:0]            i_hsize,
   input  wire logic [31:0]           i_hwdata,
   input  wire logic                  i_hready,
   output logic                       o_hreadyout,
   output logic                       o_hresp,
   output logic [31:0]                o_hrdata,
   input  wire logic                  i_main_rail_on,
   input  wire logic [7:0]            i_battery_level,
   input  wire logic                  i_chassis_intrusion,
   input  wire logic                  i_regulator_hot_a,
   input  wire logic                  i_regulator_hot_b,
   input  wire logic [TREE_WIDTH-1:0] i_tree_inputs,
   output logic                       o_diode_monitor_en,
   output logic                       o_rail_monitor_en,
   output logic                       o_battery_monitor_en,
   output logic                       o_full_monitor_en,
   output logic                       o_quiet_start_en,
   output logic                       o_intrusion_circuit_en,
   output logic                       o_intrusion_latched,
   output logic [2:0]                 o_shared_fan_drive_oe,
   output logic                       o_dedicated_fan_full,
   output logic                       o_dedicated_fan_follow,
   output logic                       o_fan_boost,
   output logic                       o_voltage_code_control,
   output logic                       o_tree_test_mode,
   output logic                       o_tree_out,
   output logic                       o_tree_out_oe,
   output logic                       o_software_restart,
   output logic                       o_irq
);
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic logic [5:0] slot_of(input logic [7:0] idx);
      logic [5:0] res;
      res = 6'h3f;
      for (int k = 0; k < NUM_CFG; k++) begin
         if (CFG_INDEX[k] == idx) begin
            res = 6'(k);
         end
      end
      return res;
   endfunction

   logic [7:0]          cfg_r [NUM_CFG];
   logic [7:0]          unlock_r;
   logic [7:0]          batt_limit_r;
   logic [NUM_EV-1:0]   irq_status_r;
   logic [NUM_EV-1:0]   irq_mask_r;
   logic [NUM_EV-1:0]   ev_set;
   logic [7:0]          addr_idx_r;
   logic                wr_pend_r;
   logic                rd_pend_r;
   logic                addr_ok_r;
   logic                accept;
   logic                wr_en;
   logic [7:0]          wdata;
   logic [5:0]          wr_slot;
   logic [7:0]          rd_val;
   logic                restart_hit;
   logic                intrusion_d_r;
   logic                hot_a_d_r;
   logic                hot_b_d_r;
   logic                circuit_en_d_r;
   logic                circuit_en;
   logic                fan_expired;
   logic                host_contact_r;
   msc_fan_state_t      fan_state_r;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   assign accept  = i_hsel && i_htrans[1] && i_hready;
   assign wr_en   = wr_pend_r && addr_ok_r;
   assign wdata   = i_hwdata[7:0];
   assign wr_slot = slot_of(addr_idx_r);

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         addr_idx_r <= 8'h00;
         addr_ok_r  <= 1'b0;
         wr_pend_r  <= 1'b0;
         rd_pend_r  <= 1'b0;
      end else begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         if (accept) begin
            addr_idx_r <= i_haddr[9:2];
            addr_ok_r  <= (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'b00);
            wr_pend_r  <= i_hwrite;
            rd_pend_r  <= !i_hwrite;
         end
      end
   end

   // reads take one wait state so a write just before is seen
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_hreadyout <= 1'b1;
         o_hrdata    <= 32'h00000000;
         o_hresp     <= 1'b0;
      end else begin
         o_hresp <= 1'b0;
         if (accept && !i_hwrite) begin
            o_hreadyout <= 1'b0;
         end else if (rd_pend_r) begin
            o_hreadyout <= 1'b1;
            o_hrdata    <= addr_ok_r ? {24'h000000, rd_val} : 32'h00000000;
         end
      end
   end

   always_comb begin
      rd_val = 8'h00;
      if (wr_slot != 6'h3f) begin
         rd_val = cfg_r[wr_slot[4:0]];
      end else if (addr_idx_r == IDX_UNLOCK) begin
         rd_val = unlock_r;
      end else if (addr_idx_r == IDX_IRQ_STATUS) begin
         rd_val = 8'(irq_status_r);
      end else if (addr_idx_r == IDX_IRQ_MASK) begin
         rd_val = 8'(irq_mask_r);
      end else if (addr_idx_r == IDX_BATT_LIMIT) begin
         rd_val = batt_limit_r;
      end else if (addr_idx_r == IDX_MON_STATUS) begin
         rd_val = {o_tree_test_mode, o_dedicated_fan_full, o_intrusion_latched,
                   o_intrusion_circuit_en, o_full_monitor_en, o_battery_monitor_en,
                   o_rail_monitor_en, o_diode_monitor_en};
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // restart only when the unlock code is in place
   assign restart_hit = wr_en && (wr_slot == 6'(SLOT_RESET_VID)) && wdata[BIT_SW_RESTART]
                        && (unlock_r == UNLOCK_CODE);

   generate
      for (genvar g = 0; g < NUM_CFG; g++) begin : g_cfg
         always_ff @(posedge i_clock or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               cfg_r[g] <= CFG_RESET[g];
            end else if (restart_hit) begin
               cfg_r[g] <= CFG_RESET[g];
            end else if (wr_en && wr_slot == 6'(g)) begin
               if (g == SLOT_RESET_VID) begin
                  cfg_r[g] <= {1'b0, wdata[6:0]};
               end else begin
                  cfg_r[g] <= wdata;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         unlock_r           <= UNLOCK_RESET;
         o_software_restart <= 1'b0;
      end else begin
         o_software_restart <= restart_hit;
         if (restart_hit) begin
            unlock_r <= UNLOCK_RESET;
         end else if (wr_en && addr_idx_r == IDX_UNLOCK) begin
            unlock_r <= wdata;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         batt_limit_r <= BATT_LIMIT_RST;
         irq_mask_r   <= NUM_EV'(IRQ_MASK_RST);
      end else if (wr_en) begin
         if (addr_idx_r == IDX_BATT_LIMIT) begin
            batt_limit_r <= wdata;
         end else if (addr_idx_r == IDX_IRQ_MASK) begin
            irq_mask_r <= wdata[NUM_EV-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // events and interrupt
   // ----------------------------------------------------------------
   assign circuit_en = (i_battery_level >= batt_limit_r);

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         intrusion_d_r  <= 1'b0;
         hot_a_d_r      <= 1'b0;
         hot_b_d_r      <= 1'b0;
         circuit_en_d_r <= 1'b0;
      end else begin
         intrusion_d_r  <= i_chassis_intrusion;
         hot_a_d_r      <= i_regulator_hot_a;
         hot_b_d_r      <= i_regulator_hot_b;
         circuit_en_d_r <= circuit_en;
      end
   end

   always_comb begin
      ev_set                 = '0;
      ev_set[EV_INTRUSION]   = i_chassis_intrusion && !intrusion_d_r && circuit_en;
      ev_set[EV_HOT_A]       = i_regulator_hot_a && !hot_a_d_r;
      ev_set[EV_HOT_B]       = i_regulator_hot_b && !hot_b_d_r;
      ev_set[EV_FAN_TIMEOUT] = fan_expired;
      ev_set[EV_BATT_LOW]    = circuit_en_d_r && !circuit_en;
   end

   // write one to clear, a new event wins over the clear
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_status_r <= '0;
      end else if (wr_en && addr_idx_r == IDX_IRQ_STATUS) begin
         irq_status_r <= (irq_status_r & ~wdata[NUM_EV-1:0]) | ev_set;
      end else begin
         irq_status_r <= irq_status_r | ev_set;
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |((irq_status_r | ev_set) & irq_mask_r);
      end
   end

   // ----------------------------------------------------------------
   // intrusion latch
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_intrusion_latched <= 1'b0;
      end else if (ev_set[EV_INTRUSION]) begin
         o_intrusion_latched <= 1'b1;
      end else if (cfg_r[SLOT_TEST_INTR][BIT_INTR_CLEAR]) begin
         o_intrusion_latched <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // monitoring enables
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_diode_monitor_en     <= 1'b0;
         o_rail_monitor_en      <= 1'b0;
         o_battery_monitor_en   <= 1'b0;
         o_full_monitor_en      <= 1'b0;
         o_quiet_start_en       <= 1'b0;
         o_intrusion_circuit_en <= 1'b0;
         o_shared_fan_drive_oe  <= 3'b000;
         o_fan_boost            <= 1'b0;
         o_voltage_code_control <= 1'b0;
      end else begin
         o_diode_monitor_en     <= 1'b1;
         o_rail_monitor_en      <= 1'b1;
         o_quiet_start_en       <= i_main_rail_on;
         o_battery_monitor_en   <= 1'b1;
         o_intrusion_circuit_en <= circuit_en;
         o_full_monitor_en      <= cfg_r[SLOT_MON_START][BIT_SETUP_DONE];
         // released pins float high until setup is done
         o_shared_fan_drive_oe  <= {3{cfg_r[SLOT_MON_START][BIT_SETUP_DONE]}};
         o_fan_boost            <= (cfg_r[SLOT_FAN_MODE][BIT_BOOST_A] && i_regulator_hot_a)
                                   || (cfg_r[SLOT_FAN_MODE][BIT_BOOST_B] && i_regulator_hot_b);
         o_voltage_code_control <= cfg_r[SLOT_RESET_VID][6];
      end
   end

   // ----------------------------------------------------------------
   // dedicated fan start-up
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         host_contact_r <= 1'b0;
      end else if (accept) begin
         host_contact_r <= 1'b1;
      end
   end

   msc_start_timer #(
      .WAIT_CYCLES (FAN_WAIT)
   ) u_start_timer (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_run     (i_main_rail_on),
      .i_cancel  (accept),
      .o_expired (fan_expired)
   );

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fan_state_r <= FAN_OFF;
      end else begin
         case (fan_state_r)
            FAN_OFF: begin
               if (accept || host_contact_r) begin
                  fan_state_r <= FAN_PROG;
               end else if (fan_expired) begin
                  fan_state_r <= FAN_FULL;
               end
            end
            FAN_FULL: begin
               if (accept) begin
                  fan_state_r <= FAN_PROG;
               end
            end
            default: begin
               fan_state_r <= FAN_PROG;
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_dedicated_fan_full   <= 1'b0;
         o_dedicated_fan_follow <= 1'b0;
      end else begin
         o_dedicated_fan_full   <= (fan_state_r == FAN_FULL);
         o_dedicated_fan_follow <= (fan_state_r == FAN_PROG);
      end
   end

   // ----------------------------------------------------------------
   // tree test
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_tree_test_mode <= 1'b0;
         o_tree_out       <= 1'b0;
         o_tree_out_oe    <= 1'b0;
      end else begin
         o_tree_test_mode <= cfg_r[SLOT_TEST_INTR][BIT_TREE_TEST];
         o_tree_out       <= 1'b0;
         // open drain: pull low for a zero, release for a one
         o_tree_out_oe    <= cfg_r[SLOT_TEST_INTR][BIT_TREE_TEST] && !(^i_tree_inputs);
      end
   end
endmodule

// ==== shared/msc_pkg.sv ====
// constants for the monitor setup and configuration register bank
package msc_pkg;
   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int         NUM_CFG        = 32;
   localparam logic [7:0] CFG_INDEX [NUM_CFG] = '{
      8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h09, 8'h0a,
      8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12,
      8'h13, 8'h14, 8'h16, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c,
      8'h1d, 8'h1e, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
   localparam logic [7:0] CFG_RESET [NUM_CFG] = '{
      8'h20, 8'h81, 8'h80, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00,
      8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h7f, 8'hce, 8'h42,
      8'hfc, 8'h01, 8'h00, 8'hff, 8'h37, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h11, 8'h31, 8'h51, 8'h71, 8'h90, 8'h90};
   // slots of the registers whose bits steer logic
   localparam int         SLOT_RESET_VID = 0;
   localparam int         SLOT_MON_START = 1;
   localparam int         SLOT_FAN_MODE  = 2;
   localparam int         SLOT_TEST_INTR = 3;
   // own registers
   localparam logic [7:0] IDX_UNLOCK     = 8'h7b;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h61;
   localparam logic [7:0] IDX_BATT_LIMIT = 8'h62;
   localparam logic [7:0] IDX_MON_STATUS = 8'h63;
   localparam logic [7:0] UNLOCK_RESET   = 8'h00;
   localparam logic [7:0] UNLOCK_CODE    = 8'h6d;
   localparam logic [7:0] BATT_LIMIT_RST = 8'h80;
   localparam logic [7:0] IRQ_MASK_RST   = 8'h00;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int         BIT_SW_RESTART = 7;
   localparam int         BIT_SETUP_DONE = 5;
   localparam int         BIT_BOOST_A    = 3;
   localparam int         BIT_BOOST_B    = 4;
   localparam int         BIT_TREE_TEST  = 6;
   localparam int         BIT_INTR_CLEAR = 5;
   // interrupt status bits
   localparam int         EV_INTRUSION   = 0;
   localparam int         EV_HOT_A       = 1;
   localparam int         EV_HOT_B       = 2;
   localparam int         EV_FAN_TIMEOUT = 3;
   localparam int         EV_BATT_LOW    = 4;
   localparam int         NUM_EV         = 5;
   localparam int         TREE_WIDTH     = 8;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int         CLOCK_KHZ      = 125000;
   localparam int         FAN_WAIT_MS    = 4600;
   localparam int         FAN_WAIT_CYC   = FAN_WAIT_MS * CLOCK_KHZ;
   localparam int         TIMER_W        = 30;
   typedef enum logic [1:0] {
      FAN_OFF  = 2'b00,
      FAN_FULL = 2'b01,
      FAN_PROG = 2'b10
   } msc_fan_state_t;
endpackage

// ==== logic/msc_start_timer.sv ====
// start-up wait timer for the dedicated fan drive
module msc_start_timer
   import msc_pkg::*;
#(
   parameter int WAIT_CYCLES = FAN_WAIT_CYC
) (
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   input  wire logic i_run,
   input  wire logic i_cancel,
   output logic      o_expired
);
   logic [TIMER_W-1:0] count_r;
   logic               done_r;

   // ----------------------------------------------------------------
   // counts while the rail is on, fires once
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count_r   <= '0;
         done_r    <= 1'b0;
         o_expired <= 1'b0;
      end else begin
         o_expired <= 1'b0;
         if (i_cancel) begin
            done_r <= 1'b1;
         end else if (i_run && !done_r) begin
            if (count_r == TIMER_W'(WAIT_CYCLES - 1)) begin
               done_r    <= 1'b1;
               o_expired <= 1'b1;
            end else begin
               count_r <= count_r + TIMER_W'(1);
            end
         end
      end
   end
endmodule

// ==== verification/msc_config_bank_monitor.sv ====
// port assertions for the config bank
// ----
// port checker
// ----
module msc_config_bank_monitor
   import msc_pkg::*;
(
   input wire logic                  i_clock,
   input wire logic                  i_sys_rst,
   input wire logic                  i_hsel,
   input wire logic [1:0]            i_htrans,
   input wire logic                  i_hwrite,
   input wire logic                  i_hready,
   input wire logic                  o_hreadyout,
   input wire logic                  o_hresp,
   input wire logic                  i_main_rail_on,
   input wire logic [TREE_WIDTH-1:0] i_tree_inputs,
   input wire logic                  o_diode_monitor_en,
   input wire logic                  o_rail_monitor_en,
   input wire logic                  o_battery_monitor_en,
   input wire logic                  o_full_monitor_en,
   input wire logic                  o_quiet_start_en,
   input wire logic [2:0]            o_shared_fan_drive_oe,
   input wire logic                  o_dedicated_fan_full,
   input wire logic                  o_dedicated_fan_follow,
   input wire logic                  o_tree_test_mode,
   input wire logic                  o_tree_out,
   input wire logic                  o_tree_out_oe,
   input wire logic                  o_software_restart
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   sequence s_rd_req; i_hsel && i_htrans[1] && i_hready && !i_hwrite; endsequence
   sequence s_rd_ans; !o_hreadyout ##1 o_hreadyout; endsequence
   property p_rd_wait; s_rd_req |=> s_rd_ans; endproperty
   property p_wr_ready; i_hsel && i_htrans[1] && i_hready && i_hwrite |=> o_hreadyout; endproperty
   property p_okay; o_hresp == 1'b0; endproperty
   property p_monitors; !$past(i_sys_rst) |-> o_diode_monitor_en && o_rail_monitor_en && o_battery_monitor_en;
   endproperty
   property p_quiet; !$past(i_sys_rst) |-> o_quiet_start_en == $past(i_main_rail_on); endproperty
   property p_shared; !o_full_monitor_en && !$past(o_full_monitor_en) |-> o_shared_fan_drive_oe == 3'b000; endproperty
   property p_fan_off; $past(i_sys_rst) |-> !o_dedicated_fan_full && !o_dedicated_fan_follow; endproperty
   property p_fan_one; !(o_dedicated_fan_full && o_dedicated_fan_follow); endproperty
   property p_tree; o_tree_test_mode && $past(o_tree_test_mode) && !$past(i_sys_rst)
      |-> o_tree_out_oe == !(^$past(i_tree_inputs)); endproperty
   property p_tree_off; !o_tree_test_mode && !$past(o_tree_test_mode) |-> !o_tree_out_oe; endproperty
   property p_od; o_tree_out == 1'b0; endproperty
   property p_pulse; o_software_restart |=> !o_software_restart; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
   a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
   a_okay: assert property (p_okay) else $error("not okay");
   a_monitors: assert property (p_monitors) else $error("monitor off");
   a_quiet: assert property (p_quiet) else $error("quiet start wrong");
   a_shared: assert property (p_shared) else $error("shared drive driven");
   a_fan_off: assert property (p_fan_off) else $error("fan not off");
   a_fan_one: assert property (p_fan_one) else $error("fan modes both on");
   a_tree: assert property (p_tree) else $error("tree output wrong");
   a_tree_off: assert property (p_tree_off) else $error("tree pull idle");
   a_od: assert property (p_od) else $error("tree pin high");
   a_pulse: assert property (p_pulse) else $error("restart long");
endmodule
bind msc_config_bank msc_config_bank_monitor mon_u (.*);

// ==== verification/msc_board_model.sv ====
// board-side model of the bank's inputs
module msc_board_model (
   input  wire logic       i_clock,
   input  wire logic       i_rail_cmd,
   input  wire logic [7:0] i_batt_cmd,
   input  wire logic       i_intr_cmd,
   input  wire logic [1:0] i_hot_cmd,
   input  wire logic [7:0] i_tree_cmd,
   output logic            o_main_rail_on      = 1'b0,
   output logic [7:0]      o_battery_level     = 8'h00,
   output logic            o_chassis_intrusion = 1'b0,
   output logic            o_regulator_hot_a   = 1'b0,
   output logic            o_regulator_hot_b   = 1'b0,
   output logic [7:0]      o_tree_inputs       = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge i_clock) begin
      o_main_rail_on      <= i_rail_cmd;
      o_battery_level     <= i_batt_cmd;
      o_chassis_intrusion <= i_intr_cmd;
      o_regulator_hot_a   <= i_hot_cmd[0];
      o_regulator_hot_b   <= i_hot_cmd[1];
      o_tree_inputs       <= i_tree_cmd;
   end
endmodule

// ==== verification/msc_config_bank_tb_top.sv ====
// bench for the config bank
module msc_config_bank_tb_top
   import msc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WAIT = 50;
   logic        i_clock = 1'b0, i_sys_rst = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0, rail_cmd = 1'b1, intr_cmd = 1'b0;
   logic [1:0]  i_htrans = 2'b00, hot_cmd = 2'b00;
   logic [2:0]  i_hsize = 3'h2, o_shared_fan_drive_oe;
   logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
   logic [7:0]  batt_cmd = 8'h90, tree_cmd = 8'h00, i_battery_level, i_tree_inputs;
   logic        o_hreadyout, o_hresp, i_main_rail_on, i_chassis_intrusion, i_regulator_hot_a, i_regulator_hot_b;
   logic        o_diode_monitor_en, o_rail_monitor_en, o_battery_monitor_en, o_full_monitor_en, o_quiet_start_en;
   logic        o_intrusion_circuit_en, o_intrusion_latched, o_dedicated_fan_full, o_dedicated_fan_follow;
   logic        o_fan_boost, o_voltage_code_control, o_tree_test_mode, o_tree_out, o_tree_out_oe;
   logic        o_software_restart, o_irq;
   logic [7:0]  tpat [4] = '{8'h00, 8'h01, 8'h81, 8'h7f};
   int          failures = 0, samples_checked = 0, pulses = 0, n;
   always #4 i_clock = ~i_clock;
   always @(negedge i_clock) if (o_software_restart === 1'b1) pulses++;
   msc_board_model board_u (.i_clock, .i_rail_cmd(rail_cmd), .i_batt_cmd(batt_cmd), .i_intr_cmd(intr_cmd),
      .i_hot_cmd(hot_cmd), .i_tree_cmd(tree_cmd), .o_main_rail_on(i_main_rail_on), .o_battery_level(i_battery_level),
      .o_chassis_intrusion(i_chassis_intrusion), .o_regulator_hot_a(i_regulator_hot_a),
      .o_regulator_hot_b(i_regulator_hot_b), .o_tree_inputs(i_tree_inputs));
   msc_config_bank #(.FAN_WAIT(WAIT)) dut_u (.*, .i_hready(o_hreadyout));
   // ----
   // tasks
   // ----
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic edge_wait(input int k);
      repeat (k) @(posedge i_clock);
      @(negedge i_clock);
   endtask
   // hold a phase until hready is high at a rising edge
   task automatic phase(inout int c, output logic [31:0] d);
      logic r;
      do begin
         @(negedge i_clock);
         r = o_hreadyout;
         d = o_hrdata;
         @(posedge i_clock);
         c++;
      end while (r !== 1'b1 && c < 40);
   endtask
   task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] wd, output logic [31:0] d);
      int c;
      c = 0;
      @(posedge i_clock);
      i_hsel   <= 1'b1;
      i_htrans <= 2'b10;
      i_haddr  <= {22'h0, idx, 2'b00};
      i_hwrite <= w;
      phase(c, d);
      i_hsel   <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= {24'h0, wd};
      phase(c, d);
      if (c >= 40) begin
         failures++;
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] d;
      bus(idx, 1'b1, v, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] d;
      bus(idx, 1'b0, 8'h00, d);
      chk($sformatf("reg %h", idx), {24'h0, e}, d);
   endtask
   // ----
   // scenarios
   // ----
   initial begin
      repeat (2) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      edge_wait(1);
      chk("early monitors", 3'b111, {o_diode_monitor_en, o_rail_monitor_en, o_battery_monitor_en});
      chk("full monitor", 1'b0, o_full_monitor_en);
      chk("shared oe", 3'b000, o_shared_fan_drive_oe);
      edge_wait(30);
      chk("fan early", 2'b00, {o_dedicated_fan_full, o_dedicated_fan_follow});
      n = 0;
      while (o_dedicated_fan_full !== 1'b1 && n < 100) begin
         edge_wait(1);
         n++;
      end
      chk("fan timeout", 1'b1, n >= WAIT - 35 && n <= WAIT - 20);
      chk("irq masked", 1'b0, o_irq);
      wr(IDX_IRQ_MASK, 8'h08);
      edge_wait(2);
      chk("fan follow", 3'b011, {o_dedicated_fan_full, o_dedicated_fan_follow, o_irq});
      rd(IDX_IRQ_STATUS, 8'h08);
      wr(IDX_IRQ_STATUS, 8'h08);
      edge_wait(2);
      chk("irq cleared", 1'b0, o_irq);
      for (int i = 0; i < NUM_CFG; i++) rd(CFG_INDEX[i], CFG_RESET[i]);
      rd(IDX_BATT_LIMIT, BATT_LIMIT_RST);
      wr(8'h20, 8'h5a);
      rd(8'h20, 8'h00);
      for (int i = NUM_CFG - 1; i >= 0; i--) if (i != SLOT_MON_START) wr(CFG_INDEX[i], ~CFG_RESET[i]);
      wr(CFG_INDEX[SLOT_MON_START], ~CFG_RESET[SLOT_MON_START]);
      for (int i = 0; i < NUM_CFG; i++) rd(CFG_INDEX[i], ~CFG_RESET[i] & (i == 0 ? 8'h7f : 8'hff));
      edge_wait(2);
      chk("locked restart", 0, pulses);
      chk("mode outputs", 6'h3f, {o_voltage_code_control, o_tree_test_mode, o_full_monitor_en, o_shared_fan_drive_oe});
      @(posedge i_clock);
      hot_cmd <= 2'b11;
      edge_wait(3);
      chk("boost", 1'b1, o_fan_boost);
      foreach (tpat[k]) begin
         @(posedge i_clock);
         tree_cmd <= tpat[k];
         edge_wait(3);
         chk("tree pull", {~^tpat[k], 1'b0}, {o_tree_out_oe, o_tree_out});
      end
      wr(IDX_UNLOCK, UNLOCK_CODE);
      wr(CFG_INDEX[SLOT_RESET_VID], 8'h80);
      edge_wait(2);
      chk("restart pulse", 1, pulses);
      rd(IDX_UNLOCK, UNLOCK_RESET);
      for (int i = 0; i < 4; i++) rd(CFG_INDEX[i], CFG_RESET[i]);
      edge_wait(2);
      chk("after restart", 6'h00, {o_fan_boost, o_tree_test_mode, o_full_monitor_en, o_shared_fan_drive_oe});
      @(posedge i_clock);
      intr_cmd <= 1'b1;
      edge_wait(8);
      chk("intrusion held", 2'b11, {o_intrusion_circuit_en, o_intrusion_latched});
      wr(CFG_INDEX[SLOT_TEST_INTR], 8'h20);
      edge_wait(2);
      chk("latch cleared", 1'b0, o_intrusion_latched);
      wr(CFG_INDEX[SLOT_TEST_INTR], 8'h00);
      @(posedge i_clock);
      intr_cmd <= 1'b0;
      batt_cmd <= BATT_LIMIT_RST - 8'h01;
      edge_wait(3);
      chk("circuit off", 1'b0, o_intrusion_circuit_en);
      @(posedge i_clock);
      intr_cmd <= 1'b1;
      edge_wait(3);
      chk("no latch", 1'b0, o_intrusion_latched);
      @(posedge i_clock);
      batt_cmd <= BATT_LIMIT_RST;
      rail_cmd <= 1'b0;
      edge_wait(3);
      chk("limit edge", 2'b10, {o_intrusion_circuit_en, o_quiet_start_en});
      rd(IDX_IRQ_STATUS, 8'h17);
      wr(IDX_IRQ_STATUS, 8'h17);
      rd(IDX_IRQ_STATUS, 8'h00);
      report_and_stop();
   end
endmodule
